// *** rtl/rtc_timebase_consts.svh ***
// Purpose: Offsets, field positions, reset values and timing figures of the timebase block.
// Assumes: System clock of 40 MHz.
// Notes: Timebase rates are phase-accumulator increments on a 24-bit accumulator.
`ifndef RTC_TIMEBASE_CONSTS_SVH
`define RTC_TIMEBASE_CONSTS_SVH

`define SYS_CLK_HZ 40000000
`define POWER_MGMT_MODE_ADDR 8'hb5
`define POWER_MGMT_MODE_RESET 8'h00
`define POWER_MGMT_MODE_MASK 8'he0
`define TIMEBASE_PIN_OUT_EN_BIT 7
`define WAKE_REQUEST_PIN_EN_BIT 6
`define SUPPLY_MONITOR_DISABLE_BIT 5

`define ACC_WIDTH 24
`define CRYSTAL_FREQ_MHZ 0.032768
`define SLOW_OSC_FREQ_KHZ 16.4
// Increment = frequency * 2^24 / 40 MHz, truncated.
`define CRYSTAL_INCREMENT 24'h0035af
`define SLOW_OSC_INCREMENT 24'h001ade
`define SELF_OSC_MIN_INCREMENT 16'h1062
`define SELF_OSC_MAX_INCREMENT 16'h4189

`define STARTUP_TICKS 16'h0400
`define MISSING_CLOCK_TIMEOUT_US 100
`define MISSING_CLOCK_COUNT_WIDTH 13

`endif

// *** rtl/rtc_timebase_pkg.sv ***
// Purpose: Types shared by the timebase block and its bench.
// Assumes: Nothing beyond the constants header.
// Notes: Codes of the source select are fixed for firmware.
package rtc_timebase_pkg;

  typedef enum logic [1:0] {
    SRC_EXT_CMOS = 2'b00,
    SRC_SLOW_OSC = 2'b01,
    SRC_OSC_CIRCUIT = 2'b10
  } timebase_source_e;

  typedef enum logic [1:0] {
    OSC_OFF = 2'b00,
    OSC_STARTING = 2'b01,
    OSC_SETTLING = 2'b10,
    OSC_READY = 2'b11
  } osc_state_e;

endpackage

// *** rtl/rtc_timebase_and_pmu_mode.sv ***
// Purpose: Timebase generation, oscillator status flags and the power management mode register.
// Assumes: Single 40 MHz clock; the timebase is modelled by one-cycle tick enables.
// Notes: Register reads return data one cycle after the address is presented.
`include "rtc_timebase_consts.svh"

// What this block does
// - Mode bit 7 drives a buffered copy of the timebase onto its pin, and leaves the pin off when clear.
// - Mode bit 6 puts the sleep wake-up request on its pin, and leaves the pin off when clear.
// - Writing one to mode bit 5 disables the supply monitor, which firmware keeps on above 2.4 V.
// - Mode bits 4 to 0 always read as zero and ignore writes.
// - The internal timebases are phase-accumulated from the system clock; only the external CMOS clock runs at its own rate.
// - The timebase comes from an external CMOS clock, the slow internal oscillator or the oscillator circuit in crystal or self-oscillate mode.
// - Rates are 32.768 kHz for crystal, 10 to 40 kHz programmable self-oscillate, and 16.4 kHz nominal for the slow oscillator.
// - Each rising timebase edge is offered as a tick to an on-chip timer for frequency measurement.
// - The timebase level is offered as a system clock source and can reach a pin even in sleep.
// - With a CMOS clock the valid flag means nothing and the fail flag is checked 2 ms after power-on.
module rtc_timebase_and_pmu_mode #(
  parameter logic [15:0] STARTUP_TICKS = `STARTUP_TICKS
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_write,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire rtc_timebase_pkg::timebase_source_e timebase_source,
  input wire logic crystal_mode_select,
  input wire logic osc_power_enable,
  input wire logic bias_double_enable,
  input wire logic [3:0] load_cap_config,
  input wire logic [15:0] self_osc_increment,
  input wire logic missing_clock_detect_en,
  input wire logic crystal_pin_a,
  input wire logic wake_request,
  output logic clock_valid_flag,
  output logic load_cap_ready_flag,
  output logic osc_fail_flag,
  output logic timebase_tick,
  output logic timebase_level,
  output logic timebase_pin_out,
  output logic timebase_pin_oe,
  output logic wake_pin_out,
  output logic wake_pin_oe,
  output logic supply_monitor_disable
);
  import rtc_timebase_pkg::*;

  localparam int MISSING_COUNT = `MISSING_CLOCK_TIMEOUT_US * (`SYS_CLK_HZ / 1000000);
  localparam logic [`MISSING_CLOCK_COUNT_WIDTH-1:0] MISSING_LIMIT =
    MISSING_COUNT[`MISSING_CLOCK_COUNT_WIDTH-1:0];

  function automatic logic [15:0] clamp_self_osc(input logic [15:0] inc);
    if (inc < `SELF_OSC_MIN_INCREMENT) begin
      clamp_self_osc = `SELF_OSC_MIN_INCREMENT;
    end else if (inc > `SELF_OSC_MAX_INCREMENT) begin
      clamp_self_osc = `SELF_OSC_MAX_INCREMENT;
    end else begin
      clamp_self_osc = inc;
    end
  endfunction

  // Mode register and pin drivers.
  logic [7:0] power_mgmt_mode;
  logic [7:0] next_power_mgmt_mode;
  logic [7:0] next_sfr_rdata;
  logic next_timebase_pin_out, next_timebase_pin_oe, next_wake_pin_out, next_wake_pin_oe;

  always_comb begin
    next_power_mgmt_mode = power_mgmt_mode;
    if (sfr_write && sfr_addr == `POWER_MGMT_MODE_ADDR) begin
      next_power_mgmt_mode = sfr_wdata & `POWER_MGMT_MODE_MASK;
    end
    next_sfr_rdata = 8'h00;
    if (sfr_addr == `POWER_MGMT_MODE_ADDR) begin
      next_sfr_rdata = power_mgmt_mode & `POWER_MGMT_MODE_MASK;
    end
    // The pin drivers follow the stored bits, so a clear takes effect one cycle later.
    next_timebase_pin_oe = power_mgmt_mode[`TIMEBASE_PIN_OUT_EN_BIT];
    next_timebase_pin_out = power_mgmt_mode[`TIMEBASE_PIN_OUT_EN_BIT] & timebase_level;
    next_wake_pin_oe = power_mgmt_mode[`WAKE_REQUEST_PIN_EN_BIT];
    next_wake_pin_out = power_mgmt_mode[`WAKE_REQUEST_PIN_EN_BIT] & wake_request;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      power_mgmt_mode <= `POWER_MGMT_MODE_RESET;
      sfr_rdata <= 8'h00;
      timebase_pin_out <= 1'b0;
      timebase_pin_oe <= 1'b0;
      wake_pin_out <= 1'b0;
      wake_pin_oe <= 1'b0;
    end else begin
      power_mgmt_mode <= next_power_mgmt_mode;
      sfr_rdata <= next_sfr_rdata;
      timebase_pin_out <= next_timebase_pin_out;
      timebase_pin_oe <= next_timebase_pin_oe;
      wake_pin_out <= next_wake_pin_out;
      wake_pin_oe <= next_wake_pin_oe;
    end
  end

  assign supply_monitor_disable = power_mgmt_mode[`SUPPLY_MONITOR_DISABLE_BIT];

  // Pin synchroniser for the external clock; the second and third stages are read.
  logic pin_sync1, pin_sync2, pin_prev;

  // The pin rests high on its pull-up, so the stages reset to that level; a
  // reset value of zero would report a false rising edge right after reset.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pin_sync1 <= 1'b1;
      pin_sync2 <= 1'b1;
      pin_prev <= 1'b1;
    end else begin
      pin_sync1 <= crystal_pin_a;
      pin_sync2 <= pin_sync1;
      pin_prev <= pin_sync2;
    end
  end

  // Timebase generation. Internal sources use a phase accumulator whose top bit is
  // the square wave, so the rate is exact on average but jitters by one clock.
  logic [`ACC_WIDTH-1:0] phase_acc, next_phase_acc, increment;
  logic [`ACC_WIDTH:0] phase_sum;
  logic next_timebase_tick, next_timebase_level, running;

  always_comb begin
    running = osc_power_enable || timebase_source == SRC_SLOW_OSC;
    case (timebase_source)
      SRC_SLOW_OSC: increment = `SLOW_OSC_INCREMENT;
      SRC_OSC_CIRCUIT: increment = crystal_mode_select ? `CRYSTAL_INCREMENT :
                                   {8'h00, clamp_self_osc(self_osc_increment)};
      default: increment = '0;
    endcase
    phase_sum = {1'b0, phase_acc} + {1'b0, increment};
    next_phase_acc = running ? phase_sum[`ACC_WIDTH-1:0] : '0;
    if (timebase_source == SRC_EXT_CMOS) begin
      next_timebase_level = pin_sync2;
      next_timebase_tick = pin_sync2 & ~pin_prev;
    end else begin
      next_timebase_level = running & phase_sum[`ACC_WIDTH-1];
      next_timebase_tick = running & phase_sum[`ACC_WIDTH-1] & ~phase_acc[`ACC_WIDTH-1];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      phase_acc <= '0;
      timebase_tick <= 1'b0;
      timebase_level <= 1'b0;
    end else begin
      phase_acc <= next_phase_acc;
      timebase_tick <= next_timebase_tick;
      timebase_level <= next_timebase_level;
    end
  end

  // Oscillator start-up: valid after enough timebase cycles, then the load
  // capacitance steps one code per tick toward its setting.
  osc_state_e osc_state, next_osc_state;
  logic [15:0] startup_count, next_startup_count, startup_limit;
  logic [3:0] load_cap_now, next_load_cap_now;

  always_comb begin
    next_osc_state = osc_state;
    next_startup_count = startup_count;
    next_load_cap_now = load_cap_now;
    // Doubled bias shortens start-up, which is why firmware starts with it on.
    startup_limit = bias_double_enable ? {1'b0, STARTUP_TICKS[15:1]} : STARTUP_TICKS;
    case (osc_state)
      OSC_OFF: begin
        next_startup_count = '0;
        if (running) begin
          next_osc_state = OSC_STARTING;
        end
      end
      OSC_STARTING: begin
        if (timebase_tick) begin
          next_startup_count = startup_count + 16'h0001;
        end
        if (startup_count >= startup_limit) begin
          next_osc_state = OSC_SETTLING;
        end
      end
      OSC_SETTLING, OSC_READY: begin
        if (timebase_tick && load_cap_now < load_cap_config) begin
          next_load_cap_now = load_cap_now + 4'h1;
        end else if (timebase_tick && load_cap_now > load_cap_config) begin
          next_load_cap_now = load_cap_now - 4'h1;
        end
        next_osc_state = (load_cap_now == load_cap_config) ? OSC_READY : OSC_SETTLING;
      end
      default: next_osc_state = OSC_OFF;
    endcase
    if (!running) begin
      next_osc_state = OSC_OFF;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      osc_state <= OSC_OFF;
      startup_count <= '0;
      load_cap_now <= '0;
    end else begin
      osc_state <= next_osc_state;
      startup_count <= next_startup_count;
      load_cap_now <= next_load_cap_now;
    end
  end

  // Status flags. The valid flag is meaningless for a CMOS clock; the fail flag is
  // the check that firmware uses in that case.
  logic [`MISSING_CLOCK_COUNT_WIDTH-1:0] miss_count, next_miss_count;
  logic next_clock_valid_flag, next_load_cap_ready_flag, next_osc_fail_flag;

  always_comb begin
    next_clock_valid_flag = osc_state == OSC_SETTLING || osc_state == OSC_READY;
    next_load_cap_ready_flag = osc_state == OSC_READY;
    next_miss_count = miss_count;
    next_osc_fail_flag = osc_fail_flag;
    if (!missing_clock_detect_en || !running) begin
      next_miss_count = '0;
      next_osc_fail_flag = 1'b0;
    end else if (timebase_tick) begin
      next_miss_count = '0;
    end else if (miss_count >= MISSING_LIMIT) begin
      next_osc_fail_flag = 1'b1;
    end else begin
      next_miss_count = miss_count + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      miss_count <= '0;
      clock_valid_flag <= 1'b0;
      load_cap_ready_flag <= 1'b0;
      osc_fail_flag <= 1'b0;
    end else begin
      miss_count <= next_miss_count;
      clock_valid_flag <= next_clock_valid_flag;
      load_cap_ready_flag <= next_load_cap_ready_flag;
      osc_fail_flag <= next_osc_fail_flag;
    end
  end

endmodule // rtc_timebase_and_pmu_mode

// *** test/rtc_timebase_checker.sv ***
// Purpose: Port assertions of the timebase block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound into the design after the module.
module rtc_timebase_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_write,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire rtc_timebase_pkg::timebase_source_e timebase_source,
  input wire logic osc_power_enable,
  input wire logic missing_clock_detect_en,
  input wire logic crystal_pin_a,
  input wire logic wake_request,
  input wire logic osc_fail_flag,
  input wire logic timebase_tick,
  input wire logic timebase_level,
  input wire logic timebase_pin_out,
  input wire logic timebase_pin_oe,
  input wire logic wake_pin_out,
  input wire logic wake_pin_oe,
  input wire logic supply_monitor_disable
);
  import rtc_timebase_pkg::*;
  logic wr;
  assign wr = sfr_write && sfr_addr == 8'hb5;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_pin_oe; wr ##1 !wr |=> timebase_pin_oe == $past(sfr_wdata[7], 2); endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin enable");
  property p_wake_oe; wr ##1 !wr |=> wake_pin_oe == $past(sfr_wdata[6], 2); endproperty
  a_wake_oe: assert property (p_wake_oe) else $error("wake enable");
  property p_mon; wr |=> supply_monitor_disable == $past(sfr_wdata[5]); endproperty
  a_mon: assert property (p_mon) else $error("monitor disable");
  property p_rd; sfr_addr != 8'hb5 |=> sfr_rdata == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read other");
  property p_pin_out; timebase_pin_out == (timebase_pin_oe && $past(timebase_level)); endproperty
  a_pin_out: assert property (p_pin_out) else $error("pin out");
  property p_wake_out; wake_pin_out == (wake_pin_oe && $past(wake_request)); endproperty
  a_wake_out: assert property (p_wake_out) else $error("wake out");
  property p_tick; timebase_tick |=> !timebase_tick; endproperty
  a_tick: assert property (p_tick) else $error("tick width");
  property p_fail; !missing_clock_detect_en [*2] |-> !osc_fail_flag; endproperty
  a_fail: assert property (p_fail) else $error("fail flag");
  property p_ext; $rose(crystal_pin_a) && osc_power_enable && timebase_source == SRC_EXT_CMOS
    |-> ##[1:4] timebase_tick; endproperty
  a_ext: assert property (p_ext) else $error("ext tick");
endmodule // rtc_timebase_checker

bind rtc_timebase_and_pmu_mode rtc_timebase_checker rtc_timebase_checker_i (.clock, .resetn,
  .sfr_addr, .sfr_write, .sfr_wdata, .sfr_rdata, .timebase_source, .osc_power_enable,
  .missing_clock_detect_en, .crystal_pin_a, .wake_request, .osc_fail_flag, .timebase_tick,
  .timebase_level, .timebase_pin_out, .timebase_pin_oe, .wake_pin_out, .wake_pin_oe,
  .supply_monitor_disable);

// *** test/cmos_clock_model.sv ***
// Purpose: External CMOS clock on the first crystal pin.
// Assumes: Unrelated in phase to the system clock.
// Notes: Faster than a real crystal to keep the run short.
module cmos_clock_model #(parameter int HALF_NS = 1937) (
  input wire logic run,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // The pin has a weak pull-up, so a stopped clock rests high.
  initial begin
    pin = 1'b1;
    forever #(HALF_NS) pin = run ? ~pin : 1'b1;
  end
endmodule // cmos_clock_model

// *** test/rtc_timebase_and_pmu_mode_tb.sv ***
// Purpose: Self-checking bench of the timebase block.
// Assumes: 40 MHz clock, start-up count cut to 4 ticks.
// Notes: Tick periods follow from the accumulator increments.
`include "rtc_timebase_consts.svh"
module rtc_timebase_and_pmu_mode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_timebase_pkg::*;
  logic clock = 1'b0, resetn = 1'b0, sfr_write = 1'b0, crystal_mode_select = 1'b0;
  logic osc_power_enable = 1'b0, bias_double_enable = 1'b0, run = 1'b0;
  logic missing_clock_detect_en = 1'b0, wake_request = 1'b0, crystal_pin_a;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, mode, a, d;
  logic [3:0] load_cap_config = 4'h3;
  logic [15:0] self_osc_increment = 16'h1062;
  timebase_source_e timebase_source = SRC_SLOW_OSC;
  logic clock_valid_flag, load_cap_ready_flag, osc_fail_flag, timebase_tick, timebase_level;
  logic timebase_pin_out, timebase_pin_oe, wake_pin_out, wake_pin_oe, supply_monitor_disable;
  int miscompares = 0, n_checks = 0, cycles = 0, n, k, i;
  rtc_timebase_and_pmu_mode #(.STARTUP_TICKS(16'h0004)) rtc_timebase_and_pmu_mode_i (
    .clock, .resetn, .sfr_addr, .sfr_write, .sfr_wdata, .sfr_rdata, .timebase_source,
    .crystal_mode_select, .osc_power_enable, .bias_double_enable, .load_cap_config,
    .self_osc_increment, .missing_clock_detect_en, .crystal_pin_a, .wake_request,
    .clock_valid_flag, .load_cap_ready_flag, .osc_fail_flag, .timebase_tick, .timebase_level,
    .timebase_pin_out, .timebase_pin_oe, .wake_pin_out, .wake_pin_oe, .supply_monitor_disable);
  cmos_clock_model cmos_clock_model_i (.run, .pin(crystal_pin_a));
  initial begin
    forever #12.5 clock = ~clock;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_near(input int got, input int exp);
    n_checks++;
    if (got < exp - 1 || got > exp + 1) begin
      miscompares++;
      $display("mismatch at %0t: period %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic write_reg(input logic [7:0] wa, input logic [7:0] wd);
    @(negedge clock);
    sfr_addr = wa;
    sfr_wdata = wd;
    sfr_write = 1'b1;
    @(negedge clock);
    sfr_write = 1'b0;
  endtask
  // Bounded, so a dead timebase ends in a mismatch and not a hang.
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(negedge clock);
      c++;
    end while (timebase_tick !== 1'b1 && c < 9000);
  endtask
  initial begin
    n = $urandom(32'h05a48742);
    repeat (10) @(negedge clock);
    resetn = 1'b1;
    check(sfr_rdata, 8'h00);
    check({5'h0, timebase_pin_oe, wake_pin_oe, supply_monitor_disable}, 8'h00);
    mode = 8'h00;
    for (k = 0; k < 16; k++) begin
      d = (k < 2) ? {8{k[0]}} : 8'($urandom);
      wake_request = d[3];
      a = (k % 5 == 4) ? 8'($urandom) & 8'hfe : 8'hb5;
      write_reg(a, d);
      // The read launched at the write edge still carries the old contents.
      check(sfr_rdata, a == 8'hb5 ? mode : 8'h00);
      if (a == 8'hb5) mode = d & 8'he0;
      check({7'h0, supply_monitor_disable}, {7'h0, mode[5]});
      sfr_addr = 8'hb5;
      @(negedge clock);
      check({6'h0, timebase_pin_oe, wake_pin_oe}, {6'h0, mode[7:6]});
      check({7'h0, wake_pin_out}, {7'h0, mode[6] & d[3]});
      check(sfr_rdata, mode);
    end
    write_reg(8'hb5, 8'hc0);
    osc_power_enable = 1'b1;
    for (k = 0; k < 5; k++) begin
      timebase_source = (k == 0) ? SRC_SLOW_OSC : SRC_OSC_CIRCUIT;
      crystal_mode_select = (k == 1);
      self_osc_increment = k == 2 ? 16'h0100 : k == 4 ? 16'hffff :
        16'($urandom_range(`SELF_OSC_MIN_INCREMENT, `SELF_OSC_MAX_INCREMENT));
      i = k == 0 ? `SLOW_OSC_INCREMENT : k == 1 ? `CRYSTAL_INCREMENT :
        k == 2 ? `SELF_OSC_MIN_INCREMENT : k == 4 ? `SELF_OSC_MAX_INCREMENT : self_osc_increment;
      wait_tick(n);
      wait_tick(n);
      check_near(n, (1 << 24) / i);
      @(negedge clock);
      check({6'h0, timebase_pin_out, timebase_level}, 8'h03);
    end
    osc_power_enable = 1'b0;
    crystal_mode_select = 1'b1;
    bias_double_enable = 1'b1;
    // The capacitance code stays at 3 from the rate runs; a new target makes it step.
    load_cap_config = 4'h7;
    repeat (3) @(negedge clock);
    check({6'h0, clock_valid_flag, load_cap_ready_flag}, 8'h00);
    osc_power_enable = 1'b1;
    k = 0;
    for (n = 0; n < 20000 && clock_valid_flag !== 1'b1; n++) begin
      @(negedge clock);
      k += timebase_tick;
    end
    check(8'(k), 8'h02);
    for (n = 0; n < 9000 && load_cap_ready_flag !== 1'b1; n++) @(negedge clock);
    // Four code steps, one per crystal tick of about 1221 cycles.
    check({6'h0, load_cap_ready_flag, n > 4800 && n < 4960}, 8'h03);
    bias_double_enable = 1'b0;
    missing_clock_detect_en = 1'b1;
    repeat (4100) @(negedge clock);
    check({6'h0, osc_fail_flag, clock_valid_flag}, 8'h01);
    osc_power_enable = 1'b0;
    repeat (3) @(negedge clock);
    check({6'h0, clock_valid_flag, load_cap_ready_flag}, 8'h00);
    timebase_source = SRC_EXT_CMOS;
    bias_double_enable = 1'b0;
    osc_power_enable = 1'b1;
    missing_clock_detect_en = 1'b1;
    repeat (3950) @(negedge clock);
    check({7'h0, osc_fail_flag}, 8'h00);
    repeat (100) @(negedge clock);
    check({7'h0, osc_fail_flag}, 8'h01);
    run = 1'b1;
    repeat (300) @(negedge clock);
    check({7'h0, osc_fail_flag}, 8'h01);
    missing_clock_detect_en = 1'b0;
    repeat (2) @(negedge clock);
    missing_clock_detect_en = 1'b1;
    repeat (4100) @(negedge clock);
    check({7'h0, osc_fail_flag}, 8'h00);
    wait_tick(n);
    wait_tick(n);
    check_near(n, 155);
    complete_run();
  end
endmodule // rtc_timebase_and_pmu_mode_tb
